// ===== ebpc_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ebpc_top
    import ebpc_pkg::*;
#(
    parameter bit WIDE16 = 1'b1
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // bus cycle requests from the core
    input wire logic cyc_valid,
    input wire ebpc_cyc_s cyc_req,
    output logic cyc_ready,
    output logic cyc_done,
    output logic [15:0] cyc_rdata,
    // straps and modes
    input wire logic addr_drive_strap_n,
    input wire logic all_pins_float_mode,
    input wire logic bus_hold_granted,
    // external bus pins
    output logic clkouta,
    output logic [19:0] addr_out,
    output logic [19:0] addr_oe,
    input wire logic [15:0] muxed_addr_data_pins_in,
    output logic [15:0] muxed_addr_data_pins_out,
    output logic [15:0] muxed_addr_data_pins_oe,
    output logic ale_out,
    output logic ale_oe,
    output logic data_direction_output,
    output logic data_direction_oe,
    output logic data_strobe_output_n,
    output logic data_strobe_oe,
    // programmable pin configuration
    output logic [31:0] pio_select,
    output logic [31:0] pio_pullup_en,
    output logic [31:0] pio_pulldown_en
);

////////////////////////////////////////////////////////////////////////////////
// register bus

logic aw_have_r, w_have_r, aw_have_nxt, w_have_nxt;
logic [11:0] waddr_r;
logic [31:0] wdata_r;
logic [3:0] wstrb_r;
logic [15:0] upper_sel_r, lower_sel_r;
logic [31:0] pio_sel_r, pio_pulldn_r;
logic [15:0] reset_cfg_r;
logic aden_low_r;
ebpc_state_e st_r, st_nxt;
logic ph_r, ph_nxt;

wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
wire ar_take = s_axi_arvalid && s_axi_arready;
wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
wire bvalid_nxt = wr_fire || (s_axi_bvalid && !s_axi_bready);
wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);
assign aw_have_nxt = aw_have_r ? !wr_fire : aw_take;
assign w_have_nxt = w_have_r ? !wr_fire : w_take;

wire w_upper = wr_fire && waddr_r == EBPC_UPPER_SEL_ADDR;
wire w_lower = wr_fire && waddr_r == EBPC_LOWER_SEL_ADDR;
wire w_pio_sel = wr_fire && waddr_r == EBPC_PIO_SEL_ADDR;
wire w_pio_pd = wr_fire && waddr_r == EBPC_PIO_PULLDN_ADDR;
wire w_ok = w_upper || w_lower || w_pio_sel || w_pio_pd;
wire [31:0] upper_mrg = ebpc_merge({16'h0000, upper_sel_r}, wdata_r, wstrb_r);
wire [31:0] lower_mrg = ebpc_merge({16'h0000, lower_sel_r}, wdata_r, wstrb_r);
wire [31:0] pio_sel_mrg = ebpc_merge(pio_sel_r, wdata_r, wstrb_r);
wire [31:0] pio_pd_mrg = ebpc_merge(pio_pulldn_r, wdata_r, wstrb_r);

wire [31:0] status_word = {24'h000000, aden_low_r, bus_hold_granted, all_pins_float_mode,
                           ph_r, 1'b0, st_r};
wire r_upper = s_axi_araddr == EBPC_UPPER_SEL_ADDR;
wire r_lower = s_axi_araddr == EBPC_LOWER_SEL_ADDR;
wire r_rcfg = s_axi_araddr == EBPC_RESET_CFG_ADDR;
wire r_psel = s_axi_araddr == EBPC_PIO_SEL_ADDR;
wire r_ppd = s_axi_araddr == EBPC_PIO_PULLDN_ADDR;
wire r_stat = s_axi_araddr == EBPC_STATUS_ADDR;
wire r_ok = r_upper || r_lower || r_rcfg || r_psel || r_ppd || r_stat;
wire [31:0] rd_word = r_upper ? {16'h0000, upper_sel_r} :
                      r_lower ? {16'h0000, lower_sel_r} :
                      r_rcfg ? {16'h0000, reset_cfg_r} :
                      r_psel ? pio_sel_r :
                      r_ppd ? pio_pulldn_r :
                      r_stat ? status_word : 32'h0000_0000;

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= EBPC_RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= EBPC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        waddr_r <= 12'h000;
        wdata_r <= 32'h0000_0000;
        wstrb_r <= 4'h0;
    end
    else
    begin
        aw_have_r <= aw_have_nxt;
        w_have_r <= w_have_nxt;
        s_axi_awready <= !aw_have_nxt;
        s_axi_wready <= !w_have_nxt;
        s_axi_bvalid <= bvalid_nxt;
        s_axi_arready <= !rvalid_nxt;
        s_axi_rvalid <= rvalid_nxt;
        if (aw_take)
            waddr_r <= s_axi_awaddr;
        if (w_take)
        begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (wr_fire)
            s_axi_bresp <= w_ok ? EBPC_RESP_OKAY : EBPC_RESP_SLVERR;
        if (ar_take)
        begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= r_ok ? EBPC_RESP_OKAY : EBPC_RESP_SLVERR;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers and reset-time capture

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        upper_sel_r <= EBPC_MEMSEL_RST;
        lower_sel_r <= EBPC_MEMSEL_RST;
        pio_sel_r <= EBPC_PIO_SEL_RST;
        pio_pulldn_r <= EBPC_PIO_PULLDN_RST;
    end
    else
    begin
        if (w_upper)
            upper_sel_r <= upper_mrg[15:0];
        if (w_lower)
            lower_sel_r <= lower_mrg[15:0];
        if (w_pio_sel)
            pio_sel_r <= pio_sel_mrg;
        if (w_pio_pd)
            pio_pulldn_r <= pio_pd_mrg & EBPC_PIO_PULLDN_WMASK;
    end
end

// sampled throughout reset, so the value at release is what stays
always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        reset_cfg_r <= muxed_addr_data_pins_in;
        aden_low_r <= !addr_drive_strap_n;
    end
end

wire [31:0] pio_sel_eff = pio_sel_r & ~(aden_low_r ? EBPC_STRAP_PINS : 32'h0000_0000);

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        pio_select <= EBPC_PIO_SEL_RST;
        pio_pullup_en <= EBPC_PIO_SEL_RST & ~EBPC_PIO_PULLDN_RST;
        pio_pulldown_en <= EBPC_PIO_SEL_RST & EBPC_PIO_PULLDN_RST;
    end
    else
    begin
        pio_select <= pio_sel_eff;
        pio_pullup_en <= pio_sel_eff & ~pio_pulldn_r;
        pio_pulldown_en <= pio_sel_eff & pio_pulldn_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus cycle sequencer: lead half-clock, then T1..T4 of two aclk each

ebpc_cyc_s req_r;
wire cyc_take = cyc_valid && cyc_ready;

always_comb
begin
    st_nxt = st_r;
    ph_nxt = 1'b0;
    unique case (st_r)
        EBPC_IDLE:
        begin
            if (cyc_take)
                st_nxt = EBPC_LEAD;
        end
        EBPC_LEAD:
            st_nxt = EBPC_T1;
        EBPC_T1, EBPC_T2, EBPC_T3, EBPC_T4:
        begin
            ph_nxt = !ph_r;
            if (ph_r)
                st_nxt = (st_r == EBPC_T4) ? EBPC_IDLE : ebpc_state_e'(st_r + 3'd1);
        end
        default:
            st_nxt = EBPC_IDLE;
    endcase
end

// upper/lower memory regions obey the disable bit only when the strap allows it
wire sel_off = req_r.upper_mem ? upper_sel_r[EBPC_ADDR_OFF_BIT] :
               req_r.lower_mem ? lower_sel_r[EBPC_ADDR_OFF_BIT] : 1'b0;
wire addr_en = aden_low_r || !sel_off;
wire drive = !bus_hold_granted && st_nxt != EBPC_IDLE;
wire t1_nxt = st_nxt == EBPC_T1;
wire dph_nxt = st_nxt == EBPC_T2 || st_nxt == EBPC_T3 || st_nxt == EBPC_T4;
wire lo_oe = drive && ((t1_nxt && addr_en) || (dph_nxt && req_r.write && req_r.wr_low));
wire hi_oe16 = drive && ((t1_nxt && addr_en) || (dph_nxt && req_r.write && req_r.wr_high));
wire hi_oe8 = drive && addr_en && (t1_nxt || dph_nxt);
wire hi_oe = WIDE16 ? hi_oe16 : hi_oe8;
wire [7:0] lo_val = t1_nxt ? req_r.addr[7:0] : req_r.wdata[7:0];
wire [7:0] hi_val = (t1_nxt || !WIDE16) ? req_r.addr[15:8] : req_r.wdata[15:8];
wire [2:0] top_oe = {3{drive}} & ~pio_sel_eff[9:7];
wire ale_nxt = t1_nxt && !ph_nxt;

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        st_r <= EBPC_IDLE;
        ph_r <= 1'b0;
        req_r <= '0;
        cyc_ready <= 1'b0;
        cyc_done <= 1'b0;
        cyc_rdata <= 16'h0000;
        clkouta <= 1'b0;
    end
    else
    begin
        st_r <= st_nxt;
        ph_r <= ph_nxt;
        if (cyc_take)
            req_r <= cyc_req;
        cyc_ready <= st_nxt == EBPC_IDLE && !bus_hold_granted;
        cyc_done <= st_r == EBPC_T4 && ph_r;
        if (st_r == EBPC_T4 && ph_r)
            cyc_rdata <= muxed_addr_data_pins_in;
        clkouta <= !clkouta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers, all registered

always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        addr_out <= 20'h00000;
        addr_oe <= 20'h00000;
        muxed_addr_data_pins_out <= 16'h0000;
        muxed_addr_data_pins_oe <= 16'h0000;
        ale_out <= 1'b0;
        ale_oe <= 1'b1;
        data_direction_output <= 1'b0;
        data_direction_oe <= 1'b0;
        data_strobe_output_n <= 1'b1;
        data_strobe_oe <= 1'b0;
    end
    else
    begin
        addr_out <= cyc_take ? cyc_req.addr : req_r.addr;
        addr_oe <= {top_oe, {17{drive}}};
        muxed_addr_data_pins_out <= {hi_val, lo_val};
        muxed_addr_data_pins_oe <= {{8{hi_oe}}, {8{lo_oe}}};
        ale_out <= ale_nxt;
        ale_oe <= !all_pins_float_mode;
        data_direction_output <= cyc_take ? cyc_req.write : req_r.write;
        data_direction_oe <= drive && !pio_sel_eff[EBPC_PIN_DIR];
        data_strobe_output_n <= !dph_nxt;
        data_strobe_oe <= drive && !pio_sel_eff[EBPC_PIN_STROBE];
    end
end

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);

sequence s_lead;
    st_r == EBPC_LEAD && !bus_hold_granted;
endsequence

sequence s_t1_addr;
    st_r == EBPC_T1 && !bus_hold_granted && addr_en;
endsequence

a_hold_float: assert property (bus_hold_granted |=> addr_oe == 20'h00000 &&
    muxed_addr_data_pins_oe == 16'h0000)
    else $error("bus driven during hold");

a_ale_float_mode: assert property (all_pins_float_mode |=> !ale_oe)
    else $error("latch strobe driven in float mode");

a_ale_in_hold: assert property (bus_hold_granted && !all_pins_float_mode |=> ale_oe)
    else $error("latch strobe released during hold");

a_addr_leads: assert property (s_lead |-> addr_oe[16:0] == 17'h1ffff &&
    muxed_addr_data_pins_oe == 16'h0000 ##2 muxed_addr_data_pins_oe != 16'h0000 ||
    !addr_en || bus_hold_granted)
    else $error("address lead order broken");

a_t1_muxed_addr: assert property (s_t1_addr |-> muxed_addr_data_pins_oe[7:0] == 8'hff &&
    muxed_addr_data_pins_out[7:0] == req_r.addr[7:0])
    else $error("low lanes miss address in T1");

a_t1_upper_addr: assert property (s_t1_addr |-> muxed_addr_data_pins_oe[15:8] == 8'hff &&
    muxed_addr_data_pins_out[15:8] == req_r.addr[15:8])
    else $error("upper lanes miss address in T1");

a_ale_fall_addr: assert property ($fell(ale_out) && st_r == EBPC_T1 |->
    $stable(muxed_addr_data_pins_out) && $stable(muxed_addr_data_pins_oe))
    else $error("address moved at latch strobe fall");

a_low_lane_float: assert property ((st_r == EBPC_T2 || st_r == EBPC_T3 || st_r == EBPC_T4) &&
    !(req_r.write && req_r.wr_low) |-> muxed_addr_data_pins_oe[7:0] == 8'h00)
    else $error("low lanes driven without byte write");

a_high_lane_float: assert property (WIDE16 && st_r inside {EBPC_T2, EBPC_T3, EBPC_T4} &&
    !(req_r.write && req_r.wr_high) |-> muxed_addr_data_pins_oe[15:8] == 8'h00)
    else $error("upper lanes driven without byte write");

a_strap_revert: assert property (aden_low_r |=> pio_select[29] == 1'b0 &&
    pio_select[26] == 1'b0)
    else $error("strap pins still programmable");

a_pio_pullup: assert property (pio_sel_r[8] && !aden_low_r |=> pio_pullup_en[8] &&
    !pio_pulldown_en[8])
    else $error("pin 8 not pulled up as PIO");

a_rcfg_capture: assert property (disable iff (1'b0) !aresetn ##1 !aresetn |=>
    reset_cfg_r == $past(muxed_addr_data_pins_in))
    else $error("reset configuration not captured");

endmodule
`default_nettype wire

// ===== ebpc_pkg.sv
package ebpc_pkg;

    // register indices and byte addresses (index times four)
    localparam logic [7:0] EBPC_UPPER_SEL_IDX = 8'ha0;
    localparam logic [7:0] EBPC_LOWER_SEL_IDX = 8'ha2;
    localparam logic [7:0] EBPC_RESET_CFG_IDX = 8'hf6;
    localparam logic [7:0] EBPC_PIO_SEL_IDX = 8'hb0;
    localparam logic [7:0] EBPC_PIO_PULLDN_IDX = 8'hb2;
    localparam logic [7:0] EBPC_STATUS_IDX = 8'hb4;
    localparam logic [11:0] EBPC_UPPER_SEL_ADDR = {2'b00, EBPC_UPPER_SEL_IDX, 2'b00};
    localparam logic [11:0] EBPC_LOWER_SEL_ADDR = {2'b00, EBPC_LOWER_SEL_IDX, 2'b00};
    localparam logic [11:0] EBPC_RESET_CFG_ADDR = {2'b00, EBPC_RESET_CFG_IDX, 2'b00};
    localparam logic [11:0] EBPC_PIO_SEL_ADDR = {2'b00, EBPC_PIO_SEL_IDX, 2'b00};
    localparam logic [11:0] EBPC_PIO_PULLDN_ADDR = {2'b00, EBPC_PIO_PULLDN_IDX, 2'b00};
    localparam logic [11:0] EBPC_STATUS_ADDR = {2'b00, EBPC_STATUS_IDX, 2'b00};

    // field positions and reset values
    localparam int EBPC_ADDR_OFF_BIT = 7;
    localparam logic [15:0] EBPC_MEMSEL_RST = 16'h0000;
    localparam logic [31:0] EBPC_PIO_SEL_RST = 32'hffff_fc07;
    localparam logic [31:0] EBPC_PIO_PULLDN_RST = 32'h0000_0402;
    localparam logic [31:0] EBPC_PIO_PULLDN_WMASK = 32'hffff_fc47;
    localparam logic [31:0] EBPC_STRAP_PINS = 32'h2400_0000;
    localparam int EBPC_PIN_DIR = 4;
    localparam int EBPC_PIN_STROBE = 5;
    localparam logic [1:0] EBPC_RESP_OKAY = 2'b00;
    localparam logic [1:0] EBPC_RESP_SLVERR = 2'b10;

    // timing: each of T1..T4 is one output clock, two aclk periods
    localparam int EBPC_ACLK_NS = 10;
    localparam int EBPC_OUTCLK_NS = 20;
    localparam int EBPC_LEAD_CYCLES = (EBPC_OUTCLK_NS / 2) / EBPC_ACLK_NS;

    typedef enum logic [2:0] {
        EBPC_IDLE = 3'b000,
        EBPC_LEAD = 3'b001,
        EBPC_T1 = 3'b010,
        EBPC_T2 = 3'b011,
        EBPC_T3 = 3'b100,
        EBPC_T4 = 3'b101
    } ebpc_state_e;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] wdata;
        logic write;
        logic wr_high;
        logic wr_low;
        logic upper_mem;
        logic lower_mem;
    } ebpc_cyc_s;

    function automatic logic [31:0] ebpc_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[8*i +: 8] = wd[8*i +: 8];
        end
        return res;
    endfunction

endpackage

// ===== ebpc_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
module ebpc_ext_mem (
    // clock
    input wire logic aclk,
    // device side of the external bus
    input wire logic ale_out,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic strobe_n,
    input wire logic dir,
    // configuration drive during reset
    input wire logic cfg_en,
    input wire logic [15:0] cfg_val,
    // resolved wire and captured address
    output logic [15:0] pin_in,
    output logic [15:0] latch_r
);
    logic [15:0] mem_r [16];
    logic [15:0] last_r = 16'h0000;
    logic [15:0] drv_val;
    logic ale_d_r = 1'b0;
    logic drv_on;

    ////////////////////////////////////////////////////////////////
    // released lines show the inverse of their last level
    assign drv_on = cfg_en || (!strobe_n && !dir);
    assign drv_val = cfg_en ? cfg_val : mem_r[latch_r[3:0]];
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (drv_on ? drv_val : ~last_r));

    initial
    begin
        latch_r = 16'h0000;
        for (int i = 0; i < 16; i++)
            mem_r[i] = {4{i[3:0]}} ^ 16'h5a5a;
    end

    always @(posedge aclk)
    begin
        last_r <= pin_in;
        ale_d_r <= ale_out;
        if (ale_d_r && !ale_out)
            latch_r <= pin_in;
        if (!strobe_n && dir)
            mem_r[latch_r[3:0]] <= (mem_r[latch_r[3:0]] & ~pin_oe) | (pin_in & pin_oe);
    end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
    import ebpc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, pio_select, pio_pullup_en, pio_pulldown_en;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cyc_valid, cyc_ready, cyc_done, addr_drive_strap_n, all_pins_float_mode;
    logic bus_hold_granted, clkouta, ale_out, ale_oe, data_direction_output;
    logic data_direction_oe, data_strobe_output_n, data_strobe_oe, cfg_en;
    ebpc_cyc_s cyc_req;
    logic [15:0] cyc_rdata, muxed_addr_data_pins_in, muxed_addr_data_pins_out;
    logic [15:0] muxed_addr_data_pins_oe, cfg_val;
    logic [15:0] shadow [16];
    logic [19:0] addr_out, addr_oe;
    logic [31:0] seed, mux_out_w, mux_oe_w;
    logic strap_low, upper_dis, lower_dis;
    int mismatches, tests_run;

    assign mux_out_w = {16'h0000, muxed_addr_data_pins_out};
    assign mux_oe_w = {16'h0000, muxed_addr_data_pins_oe};

    ebpc_top #(.WIDE16(1'b1)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cyc_valid, .cyc_req, .cyc_ready, .cyc_done,
        .cyc_rdata, .addr_drive_strap_n, .all_pins_float_mode, .bus_hold_granted,
        .clkouta, .addr_out, .addr_oe, .muxed_addr_data_pins_in, .muxed_addr_data_pins_out,
        .muxed_addr_data_pins_oe, .ale_out, .ale_oe, .data_direction_output,
        .data_direction_oe, .data_strobe_output_n, .data_strobe_oe, .pio_select,
        .pio_pullup_en, .pio_pulldown_en);

    ebpc_ext_mem u_mem (.aclk(aclk), .ale_out(ale_out), .pin_out(muxed_addr_data_pins_out),
        .pin_oe(muxed_addr_data_pins_oe), .strobe_n(data_strobe_output_n),
        .dir(data_direction_output), .cfg_en(cfg_en), .cfg_val(cfg_val),
        .pin_in(muxed_addr_data_pins_in), .latch_r());

    always #5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // address phase on the muxed pins expected for this cycle
    function automatic logic aen(input ebpc_cyc_s c);
        return strap_low || !((c.upper_mem && upper_dis) || (c.lower_mem && lower_dis));
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 50);
        chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 50);
        chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic do_reset(input logic strap_n, input logic [15:0] cfg);
        @(posedge aclk);
        aresetn <= 1'b0;
        addr_drive_strap_n <= strap_n;
        cfg_en <= 1'b1;
        cfg_val <= cfg;
        repeat (2) @(posedge aclk);
        #1;
        chk("rst_float", 32'h0, {12'h000, addr_oe} | mux_oe_w);
        chk("rst_ale_oe", 32'h1, {31'h0, ale_oe});
        @(posedge aclk);
        aresetn <= 1'b1;
        cfg_en <= 1'b0;
        repeat (2) @(posedge aclk);
        strap_low = !strap_n;
        upper_dis = 1'b0;
        lower_dis = 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic bus_cyc(input ebpc_cyc_s c, input logic hold);
        logic ae;
        logic ck;
        logic [31:0] lane;
        int n;
        ae = aen(c);
        lane = {16'h0000, {8{c.write & c.wr_high}}, {8{c.write & c.wr_low}}};
        @(posedge aclk);
        cyc_valid <= 1'b1;
        cyc_req <= c;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!cyc_ready && n < 20);
        cyc_valid <= 1'b0;
        for (int k = 1; k <= 10; k++)
        begin
            if (k > 1)
                @(posedge aclk);
            if (hold && k == 5)
                bus_hold_granted <= 1'b1;
            #1;
            if (k == 1)
            begin
                chk("lead_oe", 32'h000f_ffff, {12'h000, addr_oe});
                chk("lead_addr", {12'h000, c.addr}, {12'h000, addr_out});
                chk("lead_mux_oe", 32'h0, mux_oe_w);
            end
            if (k == 2 || k == 3)
            begin
                chk("ale", {31'h0, k == 2}, {31'h0, ale_out});
                chk("t1_oe", ae ? 32'hffff : 32'h0, mux_oe_w);
                if (ae)
                    chk("t1_addr", {16'h0000, c.addr[15:0]}, mux_out_w);
            end
            if (k == 2)
                ck = clkouta;
            if (k == 3)
                chk("clkouta", {31'h0, !ck}, {31'h0, clkouta});
            if (k >= 4 && k <= 9 && !hold)
            begin
                chk("data_oe", lane, mux_oe_w);
                chk("data", lane & c.wdata, lane & mux_out_w);
            end
            if (k == 5 && !hold)
                chk("dir_strobe", {28'h0, c.write, 3'b011},
                    {28'h0, data_direction_output, data_strobe_output_n, data_direction_oe,
                    data_strobe_oe});
            if (k >= 6 && hold)
            begin
                chk("hold_float", 32'h0, {12'h000, addr_oe} | mux_oe_w);
                chk("hold_ale_oe", 32'h1, {31'h0, ale_oe});
            end
        end
        chk("done", 32'h1, {31'h0, cyc_done});
        if (!c.write && ae && !hold)
            chk("cyc_rdata", {16'h0000, shadow[c.addr[3:0]]}, {16'h0000, cyc_rdata});
        if (c.write && ae)
            shadow[c.addr[3:0]] = (shadow[c.addr[3:0]] & ~lane[15:0]) | (c.wdata & lane[15:0]);
        if (hold)
        begin
            @(posedge aclk);
            bus_hold_granted <= 1'b0;
        end
    endtask

    task automatic rand_cyc(input logic hold);
        ebpc_cyc_s c;
        seed = xs(seed);
        if (seed[31:30] == 2'b00)
        begin
            upper_dis = seed[28];
            lower_dis = seed[27];
            axi_wr(EBPC_UPPER_SEL_ADDR, {24'h0, upper_dis, 7'h0}, EBPC_RESP_OKAY);
            axi_wr(EBPC_LOWER_SEL_ADDR, {24'h0, lower_dis, 7'h0}, EBPC_RESP_OKAY);
        end
        c.addr = seed[19:0];
        seed = xs(seed);
        c.wdata = seed[15:0];
        c.write = seed[16];
        c.wr_high = seed[17];
        c.wr_low = seed[18];
        c.upper_mem = seed[19];
        c.lower_mem = seed[20] & !seed[19];
        if (!aen(c))
            c.write = 1'b0;
        bus_cyc(c, hold);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        summarize();
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, cyc_valid, all_pins_float_mode, bus_hold_granted, cfg_en} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        {cyc_req, cfg_val, mismatches, tests_run} = '0;
        s_axi_wstrb = 4'hf;
        addr_drive_strap_n = 1'b1;
        seed = 32'hb3bd1c5c;
        for (int i = 0; i < 16; i++)
            shadow[i] = {4{i[3:0]}} ^ 16'h5a5a;
        do_reset(1'b1, seed[15:0]);
        chk("sel", 32'hffff_fc07, pio_select);
        chk("pulldown", 32'h0000_0402, pio_pulldown_en);
        chk("pullup", 32'hffff_f805, pio_pullup_en);
        axi_rd(EBPC_RESET_CFG_ADDR, {16'h0000, cfg_val}, EBPC_RESP_OKAY);
        axi_wr(EBPC_RESET_CFG_ADDR, 32'h0, EBPC_RESP_SLVERR);
        axi_rd(EBPC_RESET_CFG_ADDR, {16'h0000, cfg_val}, EBPC_RESP_OKAY);
        axi_wr(12'h004, seed, EBPC_RESP_SLVERR);
        axi_rd(12'h004, 32'h0, EBPC_RESP_SLVERR);
        axi_wr(EBPC_PIO_SEL_ADDR, 32'h0000_03f8, EBPC_RESP_OKAY);
        axi_wr(EBPC_PIO_PULLDN_ADDR, 32'h0000_0040, EBPC_RESP_OKAY);
        #1;
        chk("sel_pio", 32'h0000_03f8, pio_select);
        chk("pulldown_pio", 32'h0000_0040, pio_pulldown_en);
        chk("pullup_pio", 32'h0000_03b8, pio_pullup_en);
        axi_wr(EBPC_PIO_SEL_ADDR, 32'hffff_fc07, EBPC_RESP_OKAY);
        axi_rd(EBPC_PIO_SEL_ADDR, 32'hffff_fc07, EBPC_RESP_OKAY);
        for (int i = 0; i < 30; i++)
            rand_cyc(i == 12);
        @(posedge aclk);
        all_pins_float_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("float_ale_oe", 32'h0, {31'h0, ale_oe});
        @(posedge aclk);
        all_pins_float_mode <= 1'b0;
        do_reset(1'b0, ~cfg_val);
        chk("sel_strap", 32'hdbff_fc07, pio_select);
        axi_rd(EBPC_RESET_CFG_ADDR, {16'h0000, cfg_val}, EBPC_RESP_OKAY);
        axi_wr(EBPC_UPPER_SEL_ADDR, 32'h80, EBPC_RESP_OKAY);
        axi_wr(EBPC_LOWER_SEL_ADDR, 32'h80, EBPC_RESP_OKAY);
        axi_rd(EBPC_UPPER_SEL_ADDR, 32'h80, EBPC_RESP_OKAY);
        upper_dis = 1'b1;
        lower_dis = 1'b1;
        for (int i = 0; i < 6; i++)
            rand_cyc(1'b0);
        summarize();
    end
endmodule
`default_nettype wire
